// ==== mscfg_top.sv ====
// Motor speed, standby, brake and gate configuration logic
// ------------------------------------------------------------------
module mscfg_top
  import mscfg_pkg::*;
#(
  parameter logic [CFG_ID_W-1:0] CFG_ID = 10'h155,  // Arbitrary value
  parameter int unsigned RAMP_TICK_CYC = (CLK_HZ * SOFT_ON_S) / 511
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Register access from the serial host link
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        nv_save_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             resv_ok_o,
  // Demand sources and motor state
  input  wire logic [8:0]  i2c_demand_i,
  input  wire logic [8:0]  spd_duty_i,
  input  wire logic        speed_input_pin_i,
  input  wire logic [15:0] freq_hz_i,
  input  wire logic [15:0] motor_speed_i,
  input  wire logic [15:0] rated_speed_i,
  input  wire logic        motor_stopped_i,
  input  wire logic        brake_req_i,
  input  wire logic [2:0]  phase_high_i,
  // Drive and supervisory outputs
  output logic             run_o,
  output logic             standby_o,
  output logic             vref_en_o,
  output logic             cp_en_o,
  output logic [8:0]       amp_cmd_o,
  output logic [15:0]      speed_cmd_o,
  output logic             open_hold_o,
  output logic             cur_lim_en_o,
  output logic             brake_o,
  output logic [2:0]       gate_high_o,
  output logic [2:0]       gate_low_o,
  output logic             dt_comp_en_o,
  output logic [3:0]       gate_input_capacitance_rise_o,
  output logic [3:0]       gate_input_capacitance_fall_o
);

  if (RAMP_TICK_CYC < 1) begin : g_bad_tick
    $error("RAMP_TICK_CYC must be at least one");
  end

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  logic [15:0] work_ff [0:14];
  logic [15:0] nvm_ff  [0:14] = CFG_DEF;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  wire  [4:0]  idx       = reg_addr_i - 5'(CFG_FIRST);
  wire         addr_hit  = (reg_addr_i >= 5'(CFG_FIRST)) && (reg_addr_i <= 5'(CFG_LAST));
  wire         id_hit    = (reg_addr_i == 5'(CFG_ID_W));
  wire  [15:0] rd_word   = addr_hit ? work_ff[idx[3:0]] : 16'h0000;
  wire  [15:0] rd_val    = id_hit ? {rd_word[15:CFG_ID_W], CFG_ID} : rd_word;
  logic [14:0] fix_ok;

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 15; i++) begin
      if (rst_i) begin
        work_ff[i] <= nvm_ff[i];
      end else if (reg_wr_i && addr_hit && idx == 5'(i)) begin
        work_ff[i] <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 15; i++) begin
      if (nv_save_i) begin
        nvm_ff[i] <= work_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= rd_val;
      end
    end
  end

  // Fixed bits check, one comparator per word
  for (genvar g = 0; g < 15; g++) begin : g_fix
    assign fix_ok[g] = ((work_ff[g] ^ FIX_VAL[g]) & FIX_MASK[g]) == 16'h0000;
  end

  assign reg_rdata_o  = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign resv_ok_o    = &fix_ok;

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  mscfg_cfg_t cfg;
  wire [15:0] w_loop = work_ff[W_LOOP - CFG_FIRST];
  wire [15:0] w_misc = work_ff[W_MISC - CFG_FIRST];
  wire [15:0] w_rat  = work_ff[W_RATIO - CFG_FIRST];
  wire [15:0] w_gate = work_ff[W_GATE - CFG_FIRST];

  assign cfg.closed_loop = w_loop[B_CLOSED];
  assign cfg.clock_mode  = w_loop[B_CLKMOD];
  assign cfg.off_thr     = w_loop[B_THR +: 2];
  assign cfg.stby_en     = w_loop[B_STBY];
  assign cfg.stby_wait   = w_loop[B_STAT];
  assign cfg.brake_unc   = w_loop[B_BRKUNC];
  assign cfg.pin_src     = w_loop[B_PINSRC];
  assign cfg.safe_sel    = w_misc[B_SAFE +: 2];
  assign cfg.accel       = mscfg_buf_t'(w_misc[B_ACCEL +: 2]);
  assign cfg.decel       = mscfg_buf_t'(w_misc[B_DECEL +: 2]);
  assign cfg.open_drive  = w_misc[B_OPEN];
  assign cfg.pwr_dbg     = w_misc[B_PWRDBG];
  assign cfg.soft_on     = w_misc[B_SOFTON];
  assign cfg.soft_off    = w_misc[B_SOFTOF];
  assign cfg.soft_long   = w_misc[B_SOFT4];
  assign cfg.dt_comp     = w_misc[B_DTCOMP];
  assign cfg.ratio       = w_rat[B_RATIO +: 8];
  assign cfg.tc_shift    = w_rat[B_TC +: 4];
  assign cfg.dead        = w_gate[B_DT +: 6];
  assign cfg.gate_input_capacitance_rise   = w_gate[B_CRISE +: 4];
  assign cfg.gate_input_capacitance_fall   = w_gate[B_CFALL +: 4];

  // ----------------------------------------------------------------
  // Demand, thresholds and standby
  // ----------------------------------------------------------------
  logic       pin_s1_ff;
  logic       pin_s2_ff;
  logic       run_ff;
  logic       stby_ff;
  wire  [8:0] demand  = cfg.pin_src ? spd_duty_i : i2c_demand_i;
  wire  [8:0] thr_off = 9'((THR_PCT[cfg.off_thr] * 511) / 100);
  wire  [8:0] thr_on  = 9'(((THR_PCT[cfg.off_thr] + HYST_PCT) * 511) / 100);
  wire        nxt_run = run_ff ? (demand >= thr_off) : (demand >= thr_on);
  wire        stby_cond = cfg.stby_en && demand == 9'h000 && !pin_s2_ff
                          && (!cfg.stby_wait || motor_stopped_i);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      run_ff    <= 1'b0;
      stby_ff   <= 1'b0;
    end else begin
      pin_s1_ff <= speed_input_pin_i;
      pin_s2_ff <= pin_s1_ff;
      run_ff    <= nxt_run && !stby_cond;
      stby_ff   <= stby_cond;
    end
  end

  assign run_o     = run_ff;
  assign standby_o = stby_ff;
  assign vref_en_o = !stby_ff;
  assign cp_en_o   = !stby_ff;

  // ----------------------------------------------------------------
  // Amplitude path with buffers and soft ramps
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_ff;
  logic [1:0]  slow_div_ff;
  logic [8:0]  amp_ff;
  wire         tick     = tick_cnt_ff == 32'(RAMP_TICK_CYC - 1);
  wire         soft_tick = tick && (!cfg.soft_long
                           || slow_div_ff == 2'(SOFT_OFF_LONG_MUL - 1));
  wire  [8:0]  amp_tgt  = run_ff ? demand : 9'h000;
  wire         buf_on   = !cfg.closed_loop;
  wire mscfg_buf_t up_buf = buf_on ? cfg.accel : BUF_NONE;
  wire mscfg_buf_t dn_buf = buf_on ? cfg.decel : BUF_NONE;
  wire  [8:0]  up_step  = (up_buf == BUF_FAST && !cfg.soft_on) ? STEP_FAST : STEP_SLOW;
  wire  [8:0]  dn_step  = (dn_buf == BUF_FAST) ? STEP_FAST : STEP_SLOW;
  wire  [8:0]  up_room  = amp_tgt - amp_ff;
  wire  [8:0]  dn_room  = amp_ff - amp_tgt;
  wire  [8:0]  up_val   = (up_room > up_step) ? amp_ff + up_step : amp_tgt;
  wire  [8:0]  dn_val   = (dn_room > dn_step) ? amp_ff - dn_step : amp_tgt;
  wire         soft_dn  = !run_ff && cfg.soft_off;
  wire  [8:0]  up_next  = (up_buf == BUF_NONE && !cfg.soft_on) ? amp_tgt
                          : (tick ? up_val : amp_ff);
  wire  [8:0]  dn_next  = soft_dn ? (soft_tick ? amp_ff - STEP_SLOW : amp_ff)
                          : (dn_buf == BUF_NONE) ? amp_tgt : (tick ? dn_val : amp_ff);
  wire  [8:0]  nxt_amp  = cfg.pwr_dbg ? amp_tgt
                          : (amp_tgt > amp_ff) ? up_next
                          : (amp_tgt < amp_ff) ? dn_next : amp_ff;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      slow_div_ff <= 2'h0;
      amp_ff      <= 9'h000;
    end else begin
      slow_div_ff <= tick ? slow_div_ff + 2'h1 : slow_div_ff;
      amp_ff      <= nxt_amp;
    end
  end

  assign amp_cmd_o    = amp_ff;
  assign cur_lim_en_o = !cfg.pwr_dbg;
  assign open_hold_o  = cfg.open_drive;

  // ----------------------------------------------------------------
  // Speed target and closed-loop response
  // ----------------------------------------------------------------
  logic [15:0] spd_ff;
  wire  [23:0] clk_rpm  = freq_hz_i * cfg.ratio;
  wire  [15:0] clk_tgt  = (clk_rpm[23:16] != 8'h00) ? 16'hffff : clk_rpm[15:0];
  wire  [15:0] dem_tgt  = {amp_tgt, 7'h00};
  wire  [15:0] spd_tgt  = cfg.clock_mode ? clk_tgt : dem_tgt;
  wire  [16:0] spd_diff = {1'b0, spd_tgt} - {1'b0, spd_ff};
  wire  [16:0] spd_adj  = $signed(spd_diff) >>> cfg.tc_shift;
  wire  [15:0] nxt_spd  = (cfg.pwr_dbg || !cfg.closed_loop) ? spd_tgt
                          : (spd_adj == 17'h00000) ? spd_tgt : spd_ff + spd_adj[15:0];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      spd_ff <= 16'h0000;
    end else begin
      spd_ff <= nxt_spd;
    end
  end

  assign speed_cmd_o = spd_ff;

  // ----------------------------------------------------------------
  // Brake policy
  // ----------------------------------------------------------------
  logic        brk_ff;
  wire  [18:0] safe_lim = {3'h0, rated_speed_i} << cfg.safe_sel;
  wire         brk_safe = {3'h0, motor_speed_i} < safe_lim;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      brk_ff <= 1'b0;
    end else begin
      brk_ff <= brake_req_i && (cfg.brake_unc || brk_safe);
    end
  end

  assign brake_o = brk_ff;

  // ----------------------------------------------------------------
  // Dead-time insertion per phase
  // ----------------------------------------------------------------
  wire [11:0] dt_cyc = 12'(cfg.dead * DT_STEP_CYC);

  for (genvar p = 0; p < 3; p++) begin : g_ph
    mscfg_dt_t  st_ff;
    logic [11:0] cnt_ff;
    wire         want_hi = phase_high_i[p];
    wire         done    = cnt_ff == 12'h000;

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        st_ff  <= DT_DEAD;
        cnt_ff <= 12'h000;
      end else begin
        unique case (st_ff)
          DT_ON_LOW: begin
            if (want_hi) begin
              st_ff  <= DT_DEAD;
              cnt_ff <= dt_cyc;
            end
          end
          DT_ON_HIGH: begin
            if (!want_hi) begin
              st_ff  <= DT_DEAD;
              cnt_ff <= dt_cyc;
            end
          end
          DT_DEAD: begin
            if (done) begin
              st_ff <= want_hi ? DT_ON_HIGH : DT_ON_LOW;
            end else begin
              cnt_ff <= cnt_ff - 12'h001;
            end
          end
        endcase
      end
    end

    assign gate_high_o[p] = st_ff == DT_ON_HIGH;
    assign gate_low_o[p]  = st_ff == DT_ON_LOW;

    a_no_overlap: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(gate_high_o[p] && gate_low_o[p])) else $error("both gates on");
    a_dead_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(gate_low_o[p]) && cfg.dead != 6'h00 |-> !gate_high_o[p] [*6])
      else $error("dead time too short");
  end

  assign dt_comp_en_o = cfg.dt_comp;
  assign gate_input_capacitance_rise_o  = cfg.gate_input_capacitance_rise;
  assign gate_input_capacitance_fall_o  = cfg.gate_input_capacitance_fall;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stby_outs: assert property (@(posedge core_clk_i) disable iff (rst_i)
    standby_o |-> !vref_en_o && !cp_en_o) else $error("supplies on in standby");
  a_stby_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rst_i && cfg.stby_en && demand == 9'h000 && !pin_s2_ff && !cfg.stby_wait ##1 $stable(cfg)
    |-> standby_o) else $error("standby not entered");
  a_stby_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg.stby_wait && !motor_stopped_i |=> !standby_o) else $error("standby too early");
  a_low_duty: assert property (@(posedge core_clk_i) disable iff (rst_i)
    demand != 9'h000 && demand < thr_off |=> !run_o && !standby_o)
    else $error("low duty misread");
  a_hyst_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !run_o && demand < thr_on |=> !run_o) else $error("turned on below hysteresis");
  a_brake_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
    brake_req_i && !cfg.brake_unc && !brk_safe |=> !brake_o) else $error("unsafe brake");
  a_brake_unc: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rst_i && brake_req_i && cfg.brake_unc |=> brake_o) else $error("brake withheld");
  a_pwr_bypass: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg.pwr_dbg ##1 cfg.pwr_dbg |-> amp_cmd_o == $past(amp_tgt) && !cur_lim_en_o)
    else $error("power debug not bypassing");
  a_id_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && id_hit |=> reg_rvalid_o && reg_rdata_o[CFG_ID_W-1:0] == CFG_ID)
    else $error("wrong identifier");
  a_wr_apply: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 5'(W_LOOP) |=> w_loop == $past(reg_wdata_i))
    else $error("write not applied");

endmodule // mscfg_top

// ==== mscfg_pkg.sv ====
// Shared constants and types of the motor configuration block
package mscfg_pkg;

  // ----------------------------------------------------------------
  // Configuration word map
  // ----------------------------------------------------------------
  localparam int unsigned CFG_FIRST = 8;
  localparam int unsigned CFG_LAST  = 22;
  localparam int unsigned CFG_ID_W  = 10;

  // Fixed bit masks and values, indexed by word number minus CFG_FIRST
  localparam logic [15:0] FIX_MASK [0:14] = '{
    16'h0000, 16'h0000, 16'h1000, 16'ha317, 16'h4000, 16'hbf00, 16'hffef, 16'h3033,
    16'hc000, 16'hfc00, 16'h00ff, 16'h00ff, 16'h0000, 16'h7c1f, 16'h7000};
  localparam logic [15:0] FIX_VAL [0:14] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0100, 16'h0e05, 16'h3031,
    16'h0000, 16'h2000, 16'h000d, 16'h0000, 16'h0000, 16'h4000, 16'h1000};
  // Value of each nonvolatile word at first power-up
  localparam logic [15:0] CFG_DEF [0:14] = '{
    16'h0008, 16'h0208, 16'h0000, 16'hc880, 16'h0300, 16'h0100, 16'h0e05, 16'h3031,
    16'h0000, 16'h2000, 16'h000d, 16'h0000, 16'h0000, 16'h4000, 16'h1000};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned W_LOOP   = 11;
  localparam int unsigned B_CLOSED = 14;
  localparam int unsigned B_CLKMOD = 12;
  localparam int unsigned B_THR    = 10;
  localparam int unsigned B_STBY   = 7;
  localparam int unsigned B_STAT   = 6;
  localparam int unsigned B_BRKUNC = 5;
  localparam int unsigned B_PINSRC = 3;
  localparam int unsigned W_MISC   = 12;
  localparam int unsigned B_SAFE   = 0;
  localparam int unsigned B_ACCEL  = 2;
  localparam int unsigned B_DECEL  = 4;
  localparam int unsigned B_OPEN   = 6;
  localparam int unsigned B_PWRDBG = 7;
  localparam int unsigned B_SOFTON = 8;
  localparam int unsigned B_SOFTOF = 9;
  localparam int unsigned B_SOFT4  = 10;
  localparam int unsigned B_DTCOMP = 11;
  localparam int unsigned W_RATIO  = 8;
  localparam int unsigned B_RATIO  = 0;
  localparam int unsigned B_TC     = 8;
  localparam int unsigned W_GATE   = 9;
  localparam int unsigned B_DT     = 0;
  localparam int unsigned B_CRISE  = 6;
  localparam int unsigned B_CFALL  = 10;

  // ----------------------------------------------------------------
  // Demand scale, thresholds and timing
  // ----------------------------------------------------------------
  localparam logic [8:0]  DEM_FULL   = 9'h1ff;
  localparam int unsigned THR_PCT [0:3] = '{6, 10, 15, 20};
  localparam int unsigned HYST_PCT   = 2;
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned CLK_NS     = 10;
  localparam int unsigned DT_STEP_NS = 50;
  localparam int unsigned DT_STEP_CYC = (DT_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SOFT_ON_S  = 1;
  localparam int unsigned SOFT_OFF_LONG_MUL = 4;
  localparam logic [8:0]  STEP_FAST  = 9'h008;
  localparam logic [8:0]  STEP_SLOW  = 9'h001;

  typedef enum logic [1:0] {BUF_NONE, BUF_FAST, BUF_SLOW, BUF_RSVD} mscfg_buf_t;
  typedef enum {DT_ON_LOW, DT_DEAD, DT_ON_HIGH} mscfg_dt_t;

  // Decoded settings
  typedef struct packed {
    logic       closed_loop;
    logic       clock_mode;
    logic [1:0] off_thr;
    logic       stby_en;
    logic       stby_wait;
    logic       brake_unc;
    logic       pin_src;
    logic [1:0] safe_sel;
    mscfg_buf_t accel;
    mscfg_buf_t decel;
    logic       open_drive;
    logic       pwr_dbg;
    logic       soft_on;
    logic       soft_off;
    logic       soft_long;
    logic       dt_comp;
    logic [7:0] ratio;
    logic [3:0] tc_shift;
    logic [5:0] dead;
    logic [3:0] gate_input_capacitance_rise;
    logic [3:0] gate_input_capacitance_fall;
  } mscfg_cfg_t;

endpackage

// ==== mscfg_host.sv ====
// Host model driving configuration words, saves and demand
module mscfg_host
  import mscfg_pkg::*;
(
  // Clock and answers
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  // Link requests and demand
  output logic      [4:0]  addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [15:0] wdata_o,
  output logic             save_o,
  output logic      [8:0]  demand_o,
  output logic             pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Link tasks
  // ----------------------------------------------------------------
  initial begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
    save_o = 1'b0;
    demand_o = 9'h000;
    pin_o = 1'b0;
  end
  // Write one word; fixed bits merged unless raw
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input bit raw);
    logic [15:0] v;
    v = d;
    if (!raw && a >= 8 && a <= 22) v = (d & ~FIX_MASK[a-8]) | FIX_VAL[a-8];
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~v;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
    ok = rvalid_i;
  endtask
  task automatic save();
    @(posedge clk_i);
    save_o <= 1'b1;
    @(posedge clk_i);
    save_o <= 1'b0;
  endtask
  task automatic dem(input logic [8:0] v, input logic p);
    @(posedge clk_i);
    demand_o <= v;
    pin_o <= p;
  endtask
endmodule // mscfg_host

// ==== tb.sv ====
// Self-checking bench of the motor configuration block
module tb
  import mscfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] ID = 10'h2a6; // Arbitrary value
  logic        clk, rst, wr, rd, save, pin, rvalid, resv_ok, stopped, brk_req, live;
  logic        run, stby, vref, cp, open_hold, cur_lim, brake, dtc;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, speed_input_pin, rated, spd_cmd, freq;
  logic [8:0]  demand, amp, duty;
  logic [2:0]  ph, gh, gl;
  logic [3:0]  cr, cf;
  int          fail_count, n_compared, cyc;
  mscfg_host host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .save_o(save), .demand_o(demand), .pin_o(pin));
  mscfg_top #(.CFG_ID(ID), .RAMP_TICK_CYC(4)) uut (.core_clk_i(clk), .rst_i(rst),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .nv_save_i(save),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .resv_ok_o(resv_ok), .i2c_demand_i(demand),
    .spd_duty_i(duty), .speed_input_pin_i(pin), .freq_hz_i(freq),
    .motor_speed_i(speed_input_pin), .rated_speed_i(rated), .motor_stopped_i(stopped),
    .brake_req_i(brk_req), .phase_high_i(ph), .run_o(run), .standby_o(stby),
    .vref_en_o(vref), .cp_en_o(cp), .amp_cmd_o(amp), .speed_cmd_o(spd_cmd),
    .open_hold_o(open_hold), .cur_lim_en_o(cur_lim), .brake_o(brake), .gate_high_o(gh),
    .gate_low_o(gl), .dt_comp_en_o(dtc), .gate_input_capacitance_rise_o(cr), .gate_input_capacitance_fall_o(cf));
  // ----------------------------------------------------------------
  // Clock, reset, checks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (live && !rst) chk("overlap", 16'h0, {13'h0, gh & gl});
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [15:0] d;
    logic        v;
    host.rd(5'd10, d, v);
    chk("rvalid", 16'h1, {15'h0, v});
    chk("cfg id", {6'h0, ID}, {6'h0, d[9:0]});
    host.rd(5'd3, d, v);
    chk("unmapped", 16'h0, d);
    host.wr(5'd20, 16'ha5c3, 0);
    host.rd(5'd20, d, v);
    chk("word 20", 16'ha5c3, d);
    chk("fixed ok", 16'h1, {15'h0, resv_ok});
    host.wr(5'd11, 16'h0080, 1);
    #1;
    chk("fixed bad", 16'h0, {15'h0, resv_ok});
    host.wr(5'd9, 16'h258c, 0);
    host.wr(5'd12, 16'h0b00, 0);
    #1;
    chk("gate_input_capacitance rise", 16'h6, {12'h0, cr});
    chk("gate_input_capacitance fall", 16'h9, {12'h0, cf});
    chk("dt comp", 16'h1, {15'h0, dtc});
    $display("test regs done");
  endtask
  task automatic t_gate(input int dt);
    int n;
    @(posedge clk);
    ph <= 3'b001;
    n = 0;
    do begin
      step(1);
      n++;
    end while (gh[0] !== 1'b1 && n < 300);
    chk("dead min", 16'h1, {15'h0, n >= dt * DT_STEP_CYC});
    chk("dead max", 16'h1, {15'h0, n <= dt * DT_STEP_CYC + 3});
    chk("low off", 16'h0, {15'h0, gl[0]});
    $display("test gate done");
  endtask
  task automatic t_demand();
    int off;
    int on;
    for (int c = 0; c < 4; c++) begin
      off = THR_PCT[c] * 511 / 100;
      on = (THR_PCT[c] + HYST_PCT) * 511 / 100;
      host.wr(5'd11, {4'h8, 2'(c), 10'h000}, 0);
      host.dem(9'h000, 1'b0);
      step(5);
      chk("vref kept", 16'h1, {15'h0, vref});
      host.dem(9'(on - 1), 1'b0);
      step(2);
      chk("below on", 16'h0, {15'h0, run});
      host.dem(9'(on), 1'b0);
      step(2);
      chk("at on", 16'h1, {15'h0, run});
      host.dem(9'(off), 1'b0);
      step(2);
      chk("at off", 16'h1, {15'h0, run});
      host.dem(9'(off - 1), 1'b0);
      step(2);
      chk("below off", 16'h0, {15'h0, run});
    end
    $display("test demand done");
  endtask
  task automatic t_stby();
    host.wr(5'd11, 16'h8880, 0);
    host.dem(9'h005, 1'b0);
    step(5);
    chk("low duty stby", 16'h0, {15'h0, stby});
    chk("low duty run", 16'h0, {15'h0, run});
    host.dem(9'h000, 1'b1);
    step(5);
    chk("pin high", 16'h0, {15'h0, stby});
    host.dem(9'h000, 1'b0);
    step(5);
    chk("standby", 16'h1, {15'h0, stby});
    chk("vref off", 16'h0, {14'h0, vref, cp});
    host.dem(9'h014, 1'b1);
    host.wr(5'd11, 16'h88c0, 0);
    step(5);
    @(posedge clk);
    stopped <= 1'b0;
    host.dem(9'h000, 1'b0);
    step(6);
    chk("wait turning", 16'h0, {15'h0, stby});
    @(posedge clk);
    stopped <= 1'b1;
    step(2);
    chk("wait stopped", 16'h1, {15'h0, stby});
    $display("test standby done");
  endtask
  task automatic t_brake();
    @(posedge clk);
    brk_req <= 1'b1;
    rated <= 16'd100;
    for (int s = 0; s < 4; s++) begin
      host.wr(5'd12, {14'h00c, 2'(s)}, 0);
      speed_input_pin <= 16'((100 << s) - 1);
      step(2);
      chk("safe below", 16'h1, {15'h0, brake});
      @(posedge clk);
      speed_input_pin <= 16'(100 << s);
      step(2);
      chk("safe above", 16'h0, {15'h0, brake});
    end
    host.wr(5'd11, 16'h88a0, 0);
    step(2);
    chk("uncontrolled", 16'h1, {15'h0, brake});
    @(posedge clk);
    brk_req <= 1'b0;
    step(2);
    chk("released", 16'h0, {15'h0, brake});
    $display("test brake done");
  endtask
  task automatic t_dbg();
    host.wr(5'd12, 16'h03c0, 0);
    host.wr(5'd11, 16'h8800, 0);
    host.dem(9'h0c8, 1'b1);
    step(3);
    chk("open hold", 16'h1, {15'h0, open_hold});
    chk("cur lim", 16'h0, {15'h0, cur_lim});
    chk("amplitude", 16'h00c8, {7'h0, amp});
    host.wr(5'd12, 16'h0300, 0);
    #1;
    chk("dbg cleared", 16'h3, {14'h0, !open_hold, cur_lim});
    $display("test debug done");
  endtask
  task automatic t_save();
    logic [15:0] d;
    logic        v;
    host.wr(5'd20, 16'h1234, 0);
    host.save();
    host.wr(5'd20, 16'h4321, 0);
    do_reset();
    host.rd(5'd20, d, v);
    chk("saved word", 16'h1234, d);
    $display("test save done");
  endtask
  task automatic t_speed();
    host.wr(5'd8, 16'h0007, 0);
    host.wr(5'd11, 16'h9000, 0);
    freq <= 16'd100;
    step(2);
    chk("clock mode", 16'd700, spd_cmd);
    host.wr(5'd8, 16'h0207, 0);
    host.wr(5'd11, 16'hd000, 0);
    freq <= 16'd200;
    step(1);
    chk("closed step", 16'd875, spd_cmd);
    host.wr(5'd11, 16'h8888, 0);
    host.dem(9'h000, 1'b0);
    duty <= 9'h005;
    step(5);
    chk("pin duty low", 16'h0, {14'h0, run, stby});
    @(posedge clk);
    duty <= 9'h000;
    step(3);
    chk("pin duty zero", 16'h1, {15'h0, stby});
    host.wr(5'd12, 16'h0004, 0);
    host.wr(5'd11, 16'h8800, 0);
    step(3);
    chk("decel none", 16'h0, {7'h0, amp});
    host.dem(9'h0c8, 1'b0);
    step(8);
    chk("accel ramp", 16'h3, {14'h0, amp != 9'h000, amp < 9'h0c8});
    host.wr(5'd11, 16'hc800, 0);
    step(2);
    chk("closed no buffer", 16'h00c8, {7'h0, amp});
    $display("test speed done");
  endtask
  initial begin
    rst = 1'b1;
    ph = 3'b000;
    speed_input_pin = 16'h0000;
    rated = 16'h0064;
    stopped = 1'b1;
    brk_req = 1'b0;
    freq = 16'h0000;
    duty = 9'h000;
    live = 1'b0;
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    do_reset();
    live = 1'b1;
    t_regs();
    t_gate(12);
    t_demand();
    t_stby();
    t_brake();
    t_dbg();
    t_save();
    t_speed();
    tally_and_finish();
  end
endmodule // tb
